// [led_pump_pkg.sv]
// Purpose: Shared constants for the LED pump mode and DAC load core
// Assumes: 40 MHz system clock, AXI4-Lite register access
// Notes: Offsets are byte addresses of 32-bit words
package led_pump_pkg;
   localparam int CLK_HZ = 40000000;
   localparam int DROP_LONG_MS = 150;
   localparam int DROP_SHORT_MS = 2;
   localparam int SOFT_START_US = 125;
   localparam int PUMP_FREQ_HZ = 850000;
   localparam int DROP_LONG_CYC = CLK_HZ / 1000 * DROP_LONG_MS;
   localparam int DROP_SHORT_CYC = CLK_HZ / 1000 * DROP_SHORT_MS;
   localparam int SOFT_START_CYC = CLK_HZ / 1000000 * SOFT_START_US;
   // Half period of the pump clock, rounded down
   localparam int PUMP_HALF_CYC = CLK_HZ / (2 * PUMP_FREQ_HZ);
   localparam int NONOVL_CYC = 1;
   localparam logic [6:0] DEV_ADDR = 7'h1b; // Arbitrary
   localparam logic [7:0] ADDR_STAT = 8'h00;
   localparam logic [7:0] ADDR_CTRL = 8'h04;
   localparam logic [7:0] ADDR_PRI = 8'h08;
   localparam logic [7:0] ADDR_FLASH = 8'h0c;
   localparam logic [7:0] ADDR_OPT = 8'h10;
   localparam int OPT_AUX_LSB = 0;
   localparam int OPT_SHORT = 2;
   localparam int OPT_SELHI = 3;
   localparam int OPT_F15 = 6;
   localparam int OPT_F2 = 7;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
   typedef enum logic [2:0] {
      MODE_1X = 3'b001,
      MODE_1P5X = 3'b010,
      MODE_2X = 3'b100
   } pump_mode_e;
endpackage

// [led_pump_core.sv]
// Purpose: Pump mode logic, pump switch phasing, soft start, shutdown
//          and serial DAC loading of a multi-channel LED controller
// Assumes: Serial clock, data, flash select and dropout are asynchronous
// Notes: Registers over AXI4-Lite mirror the DAC state
`timescale 1ns/1ps
`default_nettype none
module led_pump_core
   import led_pump_pkg::*;
#(
   parameter int PRI_CH = 6,
   parameter int FLASH_CH = 1,
   parameter int DROP_LONG = DROP_LONG_CYC,
   parameter int DROP_SHORT = DROP_SHORT_CYC,
   parameter int SOFT_LEN = SOFT_START_CYC
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Serial pins
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   // Analog interface
   input wire logic flash_level_select,
   input wire logic logic_supply_low,
   input wire logic [PRI_CH-1:0] pri_dropout,
   input wire logic [FLASH_CH-1:0] flash_dropout,
   output logic [7:0] pri_code,
   output logic pri_enable,
   output logic [3:0] flash_code,
   output logic flash_enable,
   output logic [1:0] aux_code,
   output logic aux_enable,
   output logic aux_gpo_low,
   output logic shutdown,
   output logic weak_precharge,
   output logic bypass_sw,
   output logic phase1,
   output logic phase2,
   output logic cap1_charge,
   output logic cap2_charge,
   output logic caps_series,
   output logic [7:0] soft_level,
   output logic [2:0] pump_mode,
   output logic load_strobe
);
   import led_pump_pkg::*;

   // Only the two channel splits exist
   if (!((PRI_CH == 6 && FLASH_CH == 1) ||
         (PRI_CH == 5 && FLASH_CH == 2))) begin
      $error("Unsupported channel variant");
   end
   // Counters are 24 and 16 bits wide
   if (DROP_SHORT < 1 || DROP_LONG < DROP_SHORT || DROP_LONG >= (1 << 24) ||
       SOFT_LEN < 1 || SOFT_LEN > 65535) begin
      $error("Bad timing parameters");
   end

   // ----------------------------------------------------------------
   // Input synchronisers
   // ----------------------------------------------------------------
   logic [4:0] sync1_reg, sync2_reg;
   logic [PRI_CH+FLASH_CH-1:0] drop1_reg, drop2_reg;
   logic scl_d_reg, sda_d_reg, fls_d_reg;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         // Idle bus level, so no false edge follows reset
         sync1_reg <= 5'h18;
         sync2_reg <= 5'h18;
         drop1_reg <= '0;
         drop2_reg <= '0;
         scl_d_reg <= 1'b1;
         sda_d_reg <= 1'b1;
         fls_d_reg <= 1'b0;
      end else begin
         sync1_reg <= {scl_in, sda_in, flash_level_select,
                       logic_supply_low, 1'b0};
         sync2_reg <= sync1_reg;
         drop1_reg <= {pri_dropout, flash_dropout};
         drop2_reg <= drop1_reg;
         scl_d_reg <= sync2_reg[4];
         sda_d_reg <= sync2_reg[3];
         fls_d_reg <= sync2_reg[2];
      end
   end
   wire scl_s = sync2_reg[4];
   wire sda_s = sync2_reg[3];
   wire fls_s = sync2_reg[2];
   wire uvlo_s = sync2_reg[1];
   // Edges found from samples, so no serial rate floor exists
   wire scl_rise = scl_s && !scl_d_reg;
   wire scl_fall = !scl_s && scl_d_reg;
   wire start_c = scl_s && scl_d_reg && !sda_s && sda_d_reg;
   wire stop_c = scl_s && scl_d_reg && sda_s && !sda_d_reg;

   // ----------------------------------------------------------------
   // Serial slave: address byte then three data bytes
   // ----------------------------------------------------------------
   logic [7:0] shift_reg;
   logic [3:0] bit_reg;
   logic [1:0] byte_reg;
   logic active_reg, addr_ph_reg, ack_reg, wrote_reg;
   logic [7:0] hold_pri_reg, hold_flash_reg, hold_opt_reg;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         shift_reg <= 8'h00;
         bit_reg <= 4'h0;
         byte_reg <= 2'h0;
         active_reg <= 1'b0;
         addr_ph_reg <= 1'b0;
         ack_reg <= 1'b0;
         wrote_reg <= 1'b0;
         hold_pri_reg <= 8'h00;
         hold_flash_reg <= 8'h00;
         hold_opt_reg <= 8'h00;
      end else if (start_c) begin
         active_reg <= 1'b1;
         addr_ph_reg <= 1'b1;
         bit_reg <= 4'h0;
         byte_reg <= 2'h0;
         ack_reg <= 1'b0;
      end else if (stop_c) begin
         active_reg <= 1'b0;
         ack_reg <= 1'b0;
         wrote_reg <= 1'b0;
      end else if (active_reg && scl_rise && bit_reg < 4'h8) begin
         shift_reg <= {shift_reg[6:0], sda_s};
         bit_reg <= bit_reg + 4'h1;
      end else if (active_reg && scl_fall && bit_reg == 4'h8) begin
         // Ninth clock: acknowledge low on the data line
         if (addr_ph_reg) begin
            ack_reg <= (shift_reg[7:1] == DEV_ADDR) && !shift_reg[0];
            active_reg <= (shift_reg[7:1] == DEV_ADDR) && !shift_reg[0];
            addr_ph_reg <= 1'b0;
         end else begin
            ack_reg <= 1'b1;
            wrote_reg <= 1'b1;
            case (byte_reg)
               2'h0: hold_pri_reg <= shift_reg;
               2'h1: hold_flash_reg <= shift_reg;
               default: hold_opt_reg <= shift_reg;
            endcase
            byte_reg <= (byte_reg == 2'h2) ? 2'h0 : byte_reg + 2'h1;
         end
         bit_reg <= 4'h9;
      end else if (active_reg && scl_fall && bit_reg == 4'h9) begin
         ack_reg <= 1'b0;
         bit_reg <= 4'h0;
      end
   end

   // ----------------------------------------------------------------
   // DAC registers and load strobe
   // ----------------------------------------------------------------
   logic [7:0] dac_pri_reg, dac_flash_reg, dac_opt_reg;
   logic load_reg, upd_reg, gpo_reg, ctrl_gpo_reg;
   wire load_next = stop_c && wrote_reg;
   always_ff @(posedge aclk) begin
      if (!aresetn || uvlo_s) begin
         dac_pri_reg <= 8'h00;
         dac_flash_reg <= 8'h00;
         dac_opt_reg <= 8'h00;
         load_reg <= 1'b0;
         upd_reg <= 1'b0;
      end else begin
         load_reg <= load_next;
         upd_reg <= 1'b0;
         if (load_next) begin
            dac_pri_reg <= hold_pri_reg;
            dac_flash_reg <= hold_flash_reg;
            dac_opt_reg <= hold_opt_reg;
            // Any changed bit resets the pump mode unless a force bit is set
            upd_reg <= {hold_pri_reg, hold_flash_reg, hold_opt_reg} !=
                       {dac_pri_reg, dac_flash_reg, dac_opt_reg};
         end
      end
   end

   // Decoded codes
   wire sel_hi = dac_opt_reg[OPT_SELHI] || fls_s;
   wire [3:0] fl_code = sel_hi ? dac_flash_reg[7:4] : dac_flash_reg[3:0];
   wire [1:0] ax_code = dac_opt_reg[OPT_AUX_LSB+1:OPT_AUX_LSB];
   wire all_zero = (dac_pri_reg == 8'h00) && (fl_code == 4'h0) &&
                   (ax_code == 2'h0) && !ctrl_gpo_reg;
   wire sd_next = all_zero || uvlo_s;
   // Auxiliary has no dropout input at all
   wire drop_any = (|drop2_reg[PRI_CH+FLASH_CH-1:FLASH_CH] &&
                    dac_pri_reg != 8'h00) ||
                   (|drop2_reg[FLASH_CH-1:0] &&
                    fl_code != 4'h0);
   wire fls_fall = !fls_s && fls_d_reg;
   wire short_dly = dac_opt_reg[OPT_SHORT] || fls_s;

   // ----------------------------------------------------------------
   // Mode state machine
   // ----------------------------------------------------------------
   pump_mode_e mode_reg, mode_next;
   logic [23:0] drop_cnt_reg;
   wire [23:0] drop_lim = short_dly ? 24'(DROP_SHORT) : 24'(DROP_LONG);
   wire drop_done = drop_cnt_reg >= drop_lim - 24'h1;
   wire forced = dac_opt_reg[OPT_F2] || dac_opt_reg[OPT_F15];
   always_comb begin
      mode_next = mode_reg;
      if (sd_next || upd_reg || fls_fall) begin
         mode_next = MODE_1X;
      end
      if (!sd_next && forced) begin
         // Force 2x wins over force 1.5x
         mode_next = dac_opt_reg[OPT_F2] ? MODE_2X : MODE_1P5X;
      end else if (!sd_next && !upd_reg && !fls_fall && drop_any &&
                   drop_done) begin
         case (mode_reg)
            MODE_1X: mode_next = MODE_1P5X;
            MODE_1P5X: mode_next = MODE_2X;
            MODE_2X: mode_next = MODE_2X;
            default: mode_next = MODE_1X;
         endcase
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mode_reg <= MODE_1X;
         drop_cnt_reg <= 24'h0;
      end else begin
         mode_reg <= mode_next;
         // Dropout must persist unbroken
         if (!drop_any || mode_next != mode_reg || forced)
            drop_cnt_reg <= 24'h0;
         else if (!drop_done)
            drop_cnt_reg <= drop_cnt_reg + 24'h1;
      end
   end

   // ----------------------------------------------------------------
   // Pump clock, switch phasing and soft start
   // ----------------------------------------------------------------
   logic [5:0] div_reg;
   logic ph_reg;
   logic [15:0] ss_cnt_reg;
   // Uses the next shutdown value so phases stop with the shutdown flag
   wire boost = mode_reg != MODE_1X && !sd_next;
   wire [5:0] half_m1 = 6'(PUMP_HALF_CYC - 1);
   // Dead band at the start of each half period keeps phases apart
   wire dead = div_reg < 6'(NONOVL_CYC);
   always_ff @(posedge aclk) begin
      if (!aresetn || !boost) begin
         div_reg <= 6'h0;
         ph_reg <= 1'b0;
      end else if (div_reg == half_m1) begin
         div_reg <= 6'h0;
         ph_reg <= !ph_reg;
      end else begin
         div_reg <= div_reg + 6'h1;
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn || mode_next != mode_reg || !boost)
         ss_cnt_reg <= 16'h0; // Restart on each mode change, held clear outside boost
      else if (ss_cnt_reg != 16'(SOFT_LEN))
         ss_cnt_reg <= ss_cnt_reg + 16'h1;
   end

   // ----------------------------------------------------------------
   // Registered outputs
   // ----------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         {phase1, phase2, cap1_charge, cap2_charge, caps_series} <= 5'h00;
         {bypass_sw, weak_precharge, shutdown} <= 3'b011;
         soft_level <= 8'h00;
         pump_mode <= MODE_1X;
         {pri_code, flash_code, aux_code} <= 14'h0000;
         {pri_enable, flash_enable, aux_enable, aux_gpo_low} <= 4'h0;
         load_strobe <= 1'b0;
         sda_out <= 1'b0;
         sda_oe <= 1'b0;
      end else begin
         phase1 <= boost && !dead && !ph_reg;
         phase2 <= boost && !dead && ph_reg;
         // Opposite phases in 2x cut input ripple; 1.5x charges both caps on phase one
         cap1_charge <= boost && !dead &&
                        (mode_reg == MODE_2X ? !ph_reg : !ph_reg);
         cap2_charge <= boost && !dead &&
                        (mode_reg == MODE_2X ? ph_reg : !ph_reg);
         // Series charge on phase one, parallel stack on two
         caps_series <= boost && !dead && mode_reg == MODE_1P5X && !ph_reg;
         bypass_sw <= !sd_next && mode_reg == MODE_1X;
         weak_precharge <= sd_next;
         shutdown <= sd_next;
         soft_level <= boost ?
            8'((32'(ss_cnt_reg) * 255) / SOFT_LEN) : 8'h00;
         pump_mode <= mode_reg;
         pri_code <= dac_pri_reg;
         flash_code <= fl_code;
         aux_code <= ax_code;
         pri_enable <= dac_pri_reg != 8'h00;
         flash_enable <= fl_code != 4'h0;
         aux_enable <= ax_code != 2'h0;
         aux_gpo_low <= gpo_reg;
         load_strobe <= load_reg;
         sda_out <= 1'b0;
         sda_oe <= ack_reg;
      end
   end

   // ----------------------------------------------------------------
   // AXI4-Lite slave
   // ----------------------------------------------------------------
   logic aw_ok_reg, w_ok_reg, wbit_reg, wstb_reg;
   logic [7:0] aw_reg;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
         aw_ok_reg <= 1'b0;
         w_ok_reg <= 1'b0;
         aw_reg <= 8'h00;
         wbit_reg <= 1'b0;
         wstb_reg <= 1'b0;
         ctrl_gpo_reg <= 1'b0;
         gpo_reg <= 1'b0;
      end else begin
         gpo_reg <= ctrl_gpo_reg;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_reg <= s_axi_awaddr;
            aw_ok_reg <= 1'b1;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_ok_reg <= 1'b1;
            s_axi_wready <= 1'b0;
            wbit_reg <= s_axi_wdata[0];
            wstb_reg <= s_axi_wstrb[0];
         end
         if (aw_ok_reg && w_ok_reg && !s_axi_bvalid) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (aw_reg == ADDR_CTRL) ? RESP_OKAY : RESP_SLVERR;
            // Data may arrive before its address, so commit only here
            if (aw_reg == ADDR_CTRL && wstb_reg)
               ctrl_gpo_reg <= wbit_reg;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            aw_ok_reg <= 1'b0;
            w_ok_reg <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= RESP_OKAY;
         case (s_axi_araddr)
            ADDR_STAT: s_axi_rdata <= {24'h000000, shutdown, 4'h0, pump_mode};
            ADDR_CTRL: s_axi_rdata <= {31'h00000000, ctrl_gpo_reg};
            ADDR_PRI: s_axi_rdata <= {24'h000000, dac_pri_reg};
            ADDR_FLASH: s_axi_rdata <= {24'h000000, dac_flash_reg};
            ADDR_OPT: s_axi_rdata <= {24'h000000, dac_opt_reg};
            default: begin
               s_axi_rdata <= 32'h00000000;
               s_axi_rresp <= RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   a_upd_to_onex: assert property (upd_reg && !forced &&
      !sd_next |=> mode_reg == MODE_1X)
      else $error("Update did not reset mode");
   a_fall_to_onex: assert property (fls_fall && !forced |=>
      mode_reg == MODE_1X) else $error("Fall did not reset mode");
   a_onex_step: assert property (mode_reg == MODE_1X &&
      mode_next == MODE_1P5X && !forced |-> drop_any)
      else $error("Step without dropout");
   a_no_skip: assert property (mode_reg == MODE_1X && !forced |=>
      mode_reg != MODE_2X) else $error("Skipped 1.5x");
   a_force_two: assert property (dac_opt_reg[OPT_F2] &&
      !sd_next |=> mode_reg == MODE_2X) else $error("Force 2x ignored");
   a_phase_excl: assert property (!(phase1 && phase2))
      else $error("Phases overlap");
   a_shut_weak: assert property (shutdown |-> weak_precharge &&
      !phase1 && !phase2) else $error("Shutdown switches wrong");
   a_load_copy: assert property (load_next && !uvlo_s |=>
      dac_pri_reg == $past(hold_pri_reg)) else $error("Load lost");
   a_pri_enable: assert property (##1 pri_enable ==
      ($past(dac_pri_reg) != 8'h00)) else $error("Enable mismatch");
   c_step_up: cover property (mode_reg == MODE_1X ##1 mode_reg == MODE_1P5X);
   c_two_x: cover property (mode_reg == MODE_1P5X ##1 mode_reg == MODE_2X);
   c_load: cover property (load_strobe);
   c_ack: cover property (sda_oe);
endmodule
`default_nettype wire

// [i2c_host.sv]
// Purpose: Serial bus host model that loads the LED controller
// Assumes: 200 ns link period, two system clocks per quarter period
// Notes: A released data line reads high through the bus pull-up
`timescale 1ns/1ps
`default_nettype none
module i2c_host (
   // System clock
   input wire logic aclk,
   // Serial lines
   output logic scl,
   output logic sda_drv,
   input wire logic sda_line
);
   import led_pump_pkg::*;
   initial begin
      scl = 1'b1;
      sda_drv = 1'b1;
   end
   task automatic q();
      repeat (2) @(posedge aclk);
   endtask
   // Data only moves while the clock is low, so no false start or stop
   task automatic clk_bit(input logic b, output logic s);
      sda_drv <= b;
      q();
      scl <= 1'b1;
      q();
      s = sda_line;
      q();
      scl <= 1'b0;
      q();
   endtask
   task automatic xfer(input logic [23:0] d, input int n, output logic ack);
      logic s;
      logic [7:0] v;
      ack = 1'b0;
      q();
      sda_drv <= 1'b0;
      q();
      scl <= 1'b0;
      q();
      for (int k = 0; k <= n; k++) begin
         v = (k == 0) ? {DEV_ADDR, 1'b0} : d[8*(3-k) +: 8];
         for (int i = 7; i >= 0; i--) begin
            clk_bit(v[i], s);
         end
         clk_bit(1'b1, s);
         if (k == 0) begin
            ack = ~s;
         end
      end
      sda_drv <= 1'b0;
      q();
      scl <= 1'b1;
      q();
      sda_drv <= 1'b1;
      q();
      q();
   endtask
endmodule
`default_nettype wire

// [led_pump_mode_and_dac_load_tb.sv]
// Purpose: Self-checking bench for the pump mode and DAC load core
// Assumes: Shortened dropout and soft-start counts for simulation
// Notes: Host model loads data; AXI reads status and drives the GPO
`timescale 1ns/1ps
`default_nettype none
module led_pump_mode_and_dac_load_tb;
   import led_pump_pkg::*;
   logic aclk = 1'b0, aresetn = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready;
   logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, sda_out, sda_oe;
   logic [1:0] s_axi_bresp, s_axi_rresp, aux_code;
   logic flash_level_select = 0, logic_supply_low = 0, sda_drv;
   logic [5:0] pri_dropout = 6'h00;
   logic [0:0] flash_dropout = 1'b0;
   logic [7:0] pri_code, soft_level;
   logic [3:0] flash_code;
   logic [2:0] pump_mode;
   logic pri_enable, flash_enable, aux_enable, aux_gpo_low, shutdown;
   logic weak_precharge, bypass_sw, phase1, phase2, cap1_charge;
   logic cap2_charge, caps_series, load_strobe, ack;
   wire logic scl_in;
   wire logic sda_in = sda_drv & ~(sda_oe & ~sda_out);
   int bad_count = 0, total_checks = 0, strobes = 0;
   logic [31:0] rd;
   logic [1:0] rsp;
   led_pump_core #(.DROP_LONG(40), .DROP_SHORT(10), .SOFT_LEN(20)) DUT (
      .aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready), .scl_in(scl_in), .sda_in(sda_in),
      .sda_out(sda_out), .sda_oe(sda_oe),
      .flash_level_select(flash_level_select),
      .logic_supply_low(logic_supply_low), .pri_dropout(pri_dropout),
      .flash_dropout(flash_dropout), .pri_code(pri_code),
      .pri_enable(pri_enable), .flash_code(flash_code),
      .flash_enable(flash_enable), .aux_code(aux_code),
      .aux_enable(aux_enable), .aux_gpo_low(aux_gpo_low),
      .shutdown(shutdown), .weak_precharge(weak_precharge),
      .bypass_sw(bypass_sw), .phase1(phase1), .phase2(phase2),
      .cap1_charge(cap1_charge), .cap2_charge(cap2_charge),
      .caps_series(caps_series), .soft_level(soft_level),
      .pump_mode(pump_mode), .load_strobe(load_strobe));
   i2c_host host (.aclk(aclk), .scl(scl_in), .sda_drv(sda_drv),
      .sda_line(sda_in));
   always #12.5 aclk = ~aclk;
   always @(posedge aclk) begin
      if (load_strobe === 1'b1) strobes++;
      if (phase1 === 1'b1 && phase2 === 1'b1) begin
         $display("BAD phase overlap expected 0 seen 1");
         bad_count++;
      end
   end
   task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         $display("BAD %s expected %h seen %h", nm, exp, got);
         bad_count++;
      end
   endtask
   task automatic wait_mode(logic [2:0] m);
      for (int i = 0; i < 300 && pump_mode !== m; i++) @(posedge aclk);
      chk("pump_mode", m, pump_mode);
   endtask
   task automatic axi_wr(logic [7:0] a, logic [31:0] d);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      s_axi_bready <= 1;
      fork
         begin do @(posedge aclk); while (!s_axi_awready); s_axi_awvalid <= 0; end
         begin do @(posedge aclk); while (!s_axi_wready); s_axi_wvalid <= 0; end
      join
      while (!s_axi_bvalid) @(posedge aclk);
      rsp = s_axi_bresp;
      s_axi_bready <= 0;
   endtask
   task automatic axi_rd(logic [7:0] a);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      s_axi_rready <= 1;
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 0;
      while (!s_axi_rvalid) @(posedge aclk);
      rd = s_axi_rdata;
      rsp = s_axi_rresp;
      s_axi_rready <= 0;
   endtask
   task automatic t_reset();
      chk("pump_mode", MODE_1X, pump_mode);
      chk("shutdown", 1, shutdown);
      chk("weak_precharge", 1, weak_precharge);
   endtask
   task automatic t_load();
      host.xfer(24'h80a500, 3, ack);
      chk("ack", 1, ack);
      repeat (10) @(posedge aclk);
      chk("strobes", 1, strobes);
      chk("pri_code", 8'h80, pri_code);
      chk("flash_code", 4'h5, flash_code);
      chk("aux_enable", 0, aux_enable);
      chk("pri_enable", 1, pri_enable);
      chk("flash_enable", 1, flash_enable);
      chk("shutdown", 0, shutdown);
      chk("bypass_sw", 1, bypass_sw);
   endtask
   task automatic t_step();
      int ser = 0, p1 = 0, p2 = 0, both = 0;
      pri_dropout <= 6'h01;
      wait_mode(MODE_1P5X);
      chk("soft_start", 1, soft_level !== 8'hff);
      repeat (30) begin
         @(posedge aclk);
         ser += caps_series;
      end
      chk("soft_level", 8'hff, soft_level);
      chk("caps_series_seen", 1, ser > 0);
      wait_mode(MODE_2X);
      repeat (100) begin
         @(posedge aclk);
         p1 += phase1;
         p2 += phase2;
         both += cap1_charge & cap2_charge;
      end
      chk("pump_mode", MODE_2X, pump_mode);
      chk("phase1_seen", 1, p1 > 0);
      chk("phase2_seen", 1, p2 > 0);
      chk("cap_overlap", 0, both);
      pri_dropout <= 6'h00;
   endtask
   task automatic t_flash();
      flash_level_select <= 1;
      repeat (8) @(posedge aclk);
      chk("flash_code", 4'ha, flash_code);
      chk("pump_mode", MODE_2X, pump_mode);
      flash_level_select <= 0;
      wait_mode(MODE_1X);
   endtask
   task automatic t_force();
      host.xfer(24'h100083, 3, ack);
      wait_mode(MODE_2X);
      chk("aux_code", 2'h3, aux_code);
      logic_supply_low <= 1;
      repeat (10) @(posedge aclk);
      chk("pri_code", 8'h00, pri_code);
      chk("pri_enable", 0, pri_enable);
      chk("shutdown", 1, shutdown);
      logic_supply_low <= 0;
   endtask
   task automatic t_axi();
      axi_rd(ADDR_STAT);
      chk("status", 32'h81, rd);
      axi_wr(ADDR_CTRL, 32'h1);
      chk("bresp", RESP_OKAY, rsp);
      repeat (3) @(posedge aclk);
      chk("aux_gpo_low", 1, aux_gpo_low);
      axi_wr(ADDR_PRI, 32'h0);
      chk("bresp_ro", RESP_SLVERR, rsp);
      repeat (3) @(posedge aclk);
      chk("aux_gpo_low", 1, aux_gpo_low);
      axi_rd(8'h30);
      chk("rresp", RESP_SLVERR, rsp);
   endtask
   task automatic summarize();
      if (bad_count == 0 && total_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   initial begin
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      t_reset();
      t_load();
      t_step();
      t_flash();
      t_force();
      t_axi();
      summarize();
   end
   initial begin
      #1000000;
      bad_count++;
      summarize();
   end
endmodule
`default_nettype wire
